//--- core/pswc_pkg.sv
// package: constants and carrier types for the power state and wake controller
package pswc_pkg;

    // power states
    typedef enum logic [1:0] {
        PSWC_NORMAL,
        PSWC_CLK_GATE,
        PSWC_SLEEP,
        PSWC_OFF
    } pswc_state_t;

    // register map (word index = offset / 4)
    localparam logic [7:0] PSWC_REG_CTRL = 8'h00;
    localparam logic [7:0] PSWC_REG_DOMAIN = 8'h04;
    localparam logic [7:0] PSWC_REG_WAKE_EN = 8'h08;
    localparam logic [7:0] PSWC_REG_RETAIN = 8'h0c;
    localparam logic [7:0] PSWC_REG_STATUS = 8'h10;
    localparam logic [7:0] PSWC_REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] PSWC_REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] PSWC_REG_CAL = 8'h1c;

    // control register fields
    localparam int PSWC_CTRL_ENTER_SLEEP = 0;
    localparam int PSWC_CTRL_ENTER_OFF = 1;
    localparam int PSWC_CTRL_KEEP_SLOW = 2;
    localparam int PSWC_CTRL_CLK_SEL_LO = 4;
    localparam int PSWC_CTRL_DLL_EN = 6;

    // main clock select codes
    localparam logic [1:0] PSWC_CLK_RC = 2'h0;
    localparam logic [1:0] PSWC_CLK_XTAL = 2'h1;
    localparam logic [1:0] PSWC_CLK_DLL32 = 2'h2;
    localparam logic [1:0] PSWC_CLK_DLL48 = 2'h3;

    // irq/status bits
    localparam int PSWC_IRQ_WAKE = 0;
    localparam int PSWC_IRQ_RAMP = 1;
    localparam int PSWC_IRQ_XTAL = 2;
    localparam int PSWC_IRQ_CAL = 3;
    localparam int PSWC_IRQ_BITS = 4;

    // reset values
    localparam logic [31:0] PSWC_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PSWC_DOMAIN_RESET = 32'h0000_0000;
    localparam logic [31:0] PSWC_WAKE_EN_RESET = 32'h0000_0000;

    // supply ramp window: rise of 0.6 V within 100 us
    localparam int PSWC_CLK_HZ = 50_000_000;
    localparam int PSWC_RAMP_WINDOW_US = 100;
    localparam int PSWC_RAMP_WINDOW_CYC = PSWC_RAMP_WINDOW_US * (PSWC_CLK_HZ / 1_000_000);
    localparam int PSWC_RAMP_STEP_MV = 600;
    localparam int PSWC_CHIP_RESET_CYC = 16;
    localparam int PSWC_CAL_WINDOW_CYC = 1024;

    // oscillator and regulator enables
    typedef struct packed {
        logic fast_rc_osc;
        logic slow_rc_osc;
        logic rtc;
        logic bandgap;
        logic low_current_regulator;
        logic digital_regulator;
    } pswc_power_t;

    // retained pre-sleep information
    typedef struct packed {
        logic mirror_mode;
        logic [3:0] remap;
        logic [26:0] vector;
    } pswc_retain_t;

endpackage : pswc_pkg

//--- core/pswc_ctrl.sv
// power state, clock source, reset and wake controller
// Operation
// - wfi/wfe request gates core clock, state kept
// - clock-gate exit resumes core without reboot
// - enabled interrupts or events end clock gate
// - sleep/off wake sources as documented
// - fast supply rise resets whole chip
// - software writes retained mode, remap, vectors
// - programmed registers put chip into sleep
// - deep wake boots from rom, info readable
// - probe-test parts boot from second rom
// - domains switch independently in normal mode
// - oscillators and counter per power state
// - regulators per power state
// - fast rc clocks system until crystal
// - rc oscillators calibrated against crystal
// - dll provides higher clocks for selection
module pswc_ctrl
    import pswc_pkg::*;
#(
    parameter int DOMAINS = 8,
    parameter int IRQ_SRC = 16,
    parameter int RAMP_WINDOW_CYC = PSWC_RAMP_WINDOW_CYC,
    parameter int SUPPLY_MV_W = 13
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // core sleep handshake
    input wire logic core_wfi,
    input wire logic [IRQ_SRC-1:0] core_irq_src,
    output logic core_clk_en,
    output logic core_boot_mode,
    // wake and reset sources (asynchronous)
    input wire logic io_wake,
    input wire logic rtc_wake,
    input wire logic ext_reset_n,
    input wire logic uvlo_reset,
    input wire logic [SUPPLY_MV_W-1:0] supply_mv,
    input wire logic probe_test_part,
    // clock status (asynchronous)
    input wire logic crystal_ready,
    input wire logic dll_lock,
    input wire logic cal_ref_tick,
    input wire logic cal_osc_tick,
    // power and clock controls
    output pswc_power_t power_en,
    output logic crystal_osc_en,
    output logic dll_en,
    output logic [DOMAINS-1:0] domain_en,
    output logic [1:0] main_clk_sel,
    output logic probe_test_boot,
    output logic chip_reset
);

    localparam int RAMP_W = $clog2(RAMP_WINDOW_CYC + 1);
    localparam int RST_W = $clog2(PSWC_CHIP_RESET_CYC + 1);
    localparam int CAL_W = $clog2(PSWC_CAL_WINDOW_CYC + 1);
    localparam int NSYNC = 10;
    // supply samples and strap are trusted only once the synchronisers have filled
    localparam logic [2:0] SETTLE_STRAP = 3'h2;
    localparam logic [2:0] SETTLE_DONE = 3'h6;

    typedef struct packed {
        pswc_state_t state;
        logic [31:0] ctrl;
        logic [DOMAINS-1:0] domain;
        logic [IRQ_SRC-1:0] wake_en;
        pswc_retain_t retain;
        logic [PSWC_IRQ_BITS-1:0] irq_stat;
        logic [PSWC_IRQ_BITS-1:0] irq_mask;
        logic wake_pend;
        logic boot;
        logic probe_boot;
        logic strap_done;
        logic [2:0] settle;
        logic [1:0] clk_sel;
        logic [RAMP_W-1:0] ramp_cnt;
        logic [SUPPLY_MV_W-1:0] ramp_base;
        logic [RST_W-1:0] rst_cnt;
        logic [CAL_W-1:0] cal_win;
        logic [15:0] cal_cnt;
        logic [15:0] cal_result;
        logic [NSYNC-1:0] prev;
        logic [31:0] rdata;
    } pswc_regs_t;

    pswc_regs_t r;
    pswc_regs_t next_r;

    // two-flop synchronisers for all asynchronous inputs
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [SUPPLY_MV_W-1:0] mv_a;
    logic [SUPPLY_MV_W-1:0] mv_b;
    logic [SUPPLY_MV_W-1:0] mv_c;
    logic [SUPPLY_MV_W-1:0] mv_s;
    logic [IRQ_SRC-1:0] src_a;
    logic [IRQ_SRC-1:0] src_b;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= '0;
            sync_b <= '0;
            mv_a <= '0;
            mv_b <= '0;
            mv_c <= '0;
            mv_s <= '0;
            src_a <= '0;
            src_b <= '0;
        end else begin
            sync_a <= {cal_osc_tick, cal_ref_tick, dll_lock, crystal_ready, probe_test_part,
                       ~ext_reset_n, uvlo_reset, rtc_wake, io_wake, core_wfi};
            sync_b <= sync_a;
            mv_a <= supply_mv;
            mv_b <= mv_a;
            mv_c <= mv_b;
            // bits of the supply word may resolve in different cycles: take it only when steady
            if (mv_b == mv_c) begin
                mv_s <= mv_b;
            end
            src_a <= core_irq_src;
            src_b <= src_a;
        end
    end

    logic s_wfi, s_io, s_rtc, s_uvlo, s_ext, s_probe, s_xrdy, s_dlock, s_cref, s_cosc;
    assign {s_cosc, s_cref, s_dlock, s_xrdy, s_probe, s_ext, s_uvlo, s_rtc, s_io, s_wfi} = sync_b;

    function automatic logic [31:0] pad32(input logic [31:0] v);
        return v;
    endfunction

    logic deep_wake;
    logic gate_wake;
    logic ramp_trip;
    logic [SUPPLY_MV_W:0] rise;
    logic [PSWC_IRQ_BITS-1:0] irq_ev;
    logic boot_set;

    always_comb begin
        next_r = r;
        boot_set = 1'b0;
        rise = {1'b0, mv_s} - {1'b0, r.ramp_base};
        // no judgement until the first valid supply sample is the window base
        ramp_trip = (r.settle == SETTLE_DONE) && !rise[SUPPLY_MV_W]
            && (rise[SUPPLY_MV_W-1:0] > SUPPLY_MV_W'(PSWC_RAMP_STEP_MV));
        irq_ev = '0;
        gate_wake = |(src_b & r.wake_en);
        // sleep keeps rtc wake, off ignores it
        deep_wake = s_io || s_ext || s_uvlo || (r.state == PSWC_SLEEP && s_rtc);

        // capture probe-test strap once after reset release
        if (!r.strap_done && r.settle == SETTLE_STRAP) begin
            next_r.strap_done = 1'b1;
            next_r.probe_boot = s_probe;
        end

        // supply ramp monitor: compare against the lowest level since window start
        if (r.ramp_cnt == RAMP_W'(RAMP_WINDOW_CYC - 1)) begin
            next_r.ramp_cnt = '0;
            next_r.ramp_base = mv_s;
        end else begin
            next_r.ramp_cnt = r.ramp_cnt + 1'b1;
        end
        if (rise[SUPPLY_MV_W]) begin
            next_r.ramp_base = mv_s;
        end
        // after a reset the base follows the supply, else power-up itself looks like a ramp
        if (r.settle != SETTLE_DONE) begin
            next_r.settle = r.settle + 1'b1;
            next_r.ramp_base = mv_s;
            next_r.ramp_cnt = '0;
        end
        if (r.rst_cnt != '0) begin
            next_r.rst_cnt = r.rst_cnt - 1'b1;
        end

        // wake latch: set while entering so an early wake is not lost
        if (r.state != PSWC_NORMAL && (deep_wake || gate_wake)) begin
            next_r.wake_pend = 1'b1;
        end

        case (r.state)
            PSWC_NORMAL: begin
                next_r.wake_pend = 1'b0;
                if (r.ctrl[PSWC_CTRL_ENTER_OFF]) begin
                    next_r.state = PSWC_OFF;
                    next_r.clk_sel = PSWC_CLK_RC;
                    // a wake already present at entry is carried into the deep state
                    next_r.wake_pend = s_io || s_ext || s_uvlo;
                end else if (r.ctrl[PSWC_CTRL_ENTER_SLEEP]) begin
                    next_r.state = PSWC_SLEEP;
                    next_r.clk_sel = PSWC_CLK_RC;
                    next_r.wake_pend = s_io || s_ext || s_uvlo || s_rtc;
                end else if (s_wfi && !gate_wake) begin
                    next_r.state = PSWC_CLK_GATE;
                end
            end
            PSWC_CLK_GATE: begin
                // resume in place: no boot flag, registers untouched
                if (gate_wake || r.wake_pend) begin
                    next_r.state = PSWC_NORMAL;
                    next_r.wake_pend = 1'b0;
                    irq_ev[PSWC_IRQ_WAKE] = 1'b1;
                end
            end
            PSWC_SLEEP, PSWC_OFF: begin
                if (deep_wake || r.wake_pend) begin
                    next_r.state = PSWC_NORMAL;
                    next_r.boot = 1'b1;
                    boot_set = 1'b1;
                    next_r.wake_pend = 1'b0;
                    next_r.ctrl[PSWC_CTRL_ENTER_SLEEP] = 1'b0;
                    next_r.ctrl[PSWC_CTRL_ENTER_OFF] = 1'b0;
                    irq_ev[PSWC_IRQ_WAKE] = 1'b1;
                end else begin
                    next_r.wake_pend = 1'b0;
                end
            end
            default: begin
                next_r.state = PSWC_NORMAL;
            end
        endcase

        // main clock: rc until crystal is ready, switch only when running
        if (r.state == PSWC_NORMAL) begin
            if (!s_xrdy) begin
                next_r.clk_sel = PSWC_CLK_RC;
            end else if (r.ctrl[PSWC_CTRL_CLK_SEL_LO +: 2] == PSWC_CLK_XTAL) begin
                next_r.clk_sel = PSWC_CLK_XTAL;
            end else if (r.ctrl[PSWC_CTRL_CLK_SEL_LO +: 2] != PSWC_CLK_RC && s_dlock) begin
                next_r.clk_sel = r.ctrl[PSWC_CTRL_CLK_SEL_LO +: 2];
            end else if (r.ctrl[PSWC_CTRL_CLK_SEL_LO +: 2] == PSWC_CLK_RC) begin
                next_r.clk_sel = PSWC_CLK_RC;
            end
        end
        if (s_xrdy && !r.prev[5]) begin
            irq_ev[PSWC_IRQ_XTAL] = 1'b1;
        end

        // calibration: count rc ticks over a window of crystal ticks
        if (s_xrdy) begin
            if (s_cosc && !r.prev[9]) begin
                next_r.cal_cnt = r.cal_cnt + 1'b1;
            end
            if (s_cref && !r.prev[8]) begin
                if (r.cal_win == CAL_W'(PSWC_CAL_WINDOW_CYC - 1)) begin
                    next_r.cal_win = '0;
                    next_r.cal_result = r.cal_cnt;
                    next_r.cal_cnt = '0;
                    irq_ev[PSWC_IRQ_CAL] = 1'b1;
                end else begin
                    next_r.cal_win = r.cal_win + 1'b1;
                end
            end
        end
        next_r.prev = sync_b;

        if (ramp_trip) begin
            next_r.rst_cnt = RST_W'(PSWC_CHIP_RESET_CYC);
            next_r.ramp_base = mv_s;
            irq_ev[PSWC_IRQ_RAMP] = 1'b1;
        end

        // register port; retained block survives sleep/off
        next_r.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                PSWC_REG_CTRL: next_r.ctrl = reg_wdata;
                PSWC_REG_DOMAIN: next_r.domain = reg_wdata[DOMAINS-1:0];
                PSWC_REG_WAKE_EN: next_r.wake_en = reg_wdata[IRQ_SRC-1:0];
                PSWC_REG_RETAIN: next_r.retain = reg_wdata;
                PSWC_REG_IRQ_MASK: next_r.irq_mask = reg_wdata[PSWC_IRQ_BITS-1:0];
                // a deep wake in the same cycle wins over the clear
                PSWC_REG_STATUS: next_r.boot = boot_set | (r.boot & ~reg_wdata[2]);
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                PSWC_REG_CTRL: next_r.rdata = r.ctrl;
                PSWC_REG_DOMAIN: next_r.rdata = pad32(32'(r.domain));
                PSWC_REG_WAKE_EN: next_r.rdata = pad32(32'(r.wake_en));
                PSWC_REG_RETAIN: next_r.rdata = r.retain;
                PSWC_REG_STATUS: next_r.rdata = {25'h0, r.probe_boot, r.clk_sel, s_dlock, r.boot,
                                                 r.state};
                PSWC_REG_IRQ_STAT: begin
                    next_r.rdata = pad32(32'(r.irq_stat));
                    next_r.irq_stat = '0;
                end
                PSWC_REG_IRQ_MASK: next_r.rdata = pad32(32'(r.irq_mask));
                PSWC_REG_CAL: next_r.rdata = {16'h0, r.cal_result};
                default: next_r.rdata = '0;
            endcase
        end
        // new events win over the read-clear
        next_r.irq_stat = next_r.irq_stat | irq_ev;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.ctrl <= PSWC_CTRL_RESET;
            r.domain <= DOMAINS'(PSWC_DOMAIN_RESET);
            r.wake_en <= IRQ_SRC'(PSWC_WAKE_EN_RESET);
            r.boot <= 1'b1;
        end else if (r.rst_cnt != '0 && next_r.rst_cnt != '0) begin
            // whole-chip reset holds the controller's own state at power-up values
            r <= '0;
            r.rst_cnt <= next_r.rst_cnt;
            r.boot <= 1'b1;
            // retained block and edge history survive; the cause stays visible afterwards
            r.retain <= r.retain;
            r.prev <= next_r.prev;
            r.irq_stat[PSWC_IRQ_RAMP] <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq = |(r.irq_stat & r.irq_mask);
    assign core_clk_en = (r.state == PSWC_NORMAL);
    assign core_boot_mode = r.boot;
    assign probe_test_boot = r.probe_boot & r.boot;
    assign chip_reset = (r.rst_cnt != '0);
    assign main_clk_sel = r.clk_sel;
    assign crystal_osc_en = (r.state == PSWC_NORMAL) || (r.state == PSWC_CLK_GATE);
    assign dll_en = crystal_osc_en && r.ctrl[PSWC_CTRL_DLL_EN];
    assign domain_en = (r.state == PSWC_SLEEP || r.state == PSWC_OFF) ? '0 : r.domain;

    always_comb begin
        power_en = '0;
        case (r.state)
            PSWC_NORMAL, PSWC_CLK_GATE: begin
                power_en = '1;
            end
            PSWC_SLEEP: begin
                power_en.slow_rc_osc = r.ctrl[PSWC_CTRL_KEEP_SLOW];
                power_en.rtc = r.ctrl[PSWC_CTRL_KEEP_SLOW];
                power_en.low_current_regulator = 1'b1;
            end
            default: power_en = '0;
        endcase
    end

endmodule // pswc_ctrl

//--- test/pswc_ctrl_chk.sv
// checker: port-level assertions for the power state and wake controller
module pswc_ctrl_chk
    import pswc_pkg::*;
#(
    parameter int IRQ_SRC = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // core and wake sources
    input wire logic core_wfi,
    input wire logic [IRQ_SRC-1:0] core_irq_src,
    input wire logic core_clk_en,
    input wire logic core_boot_mode,
    input wire logic io_wake,
    input wire logic rtc_wake,
    // clocks and power
    input wire logic crystal_ready,
    input wire logic dll_lock,
    input wire pswc_power_t power_en,
    input wire logic [1:0] main_clk_sel,
    input wire logic chip_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [IRQ_SRC-1:0] wake_mask;
    logic [4:0] rst_run;
    logic deep;
    // digital regulator off means sleep or off
    assign deep = !power_en.digital_regulator;
    // shadow of the wake mask, since the register itself is not visible here
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_mask <= '0;
            rst_run <= 5'h0;
        end else begin
            if (reg_wr && reg_addr == PSWC_REG_WAKE_EN) begin
                wake_mask <= reg_wdata[IRQ_SRC-1:0];
            end
            rst_run <= chip_reset ? rst_run + 5'h1 : 5'h0;
        end
    end
    sequence s_wfi_idle;
        (core_wfi && core_clk_en && !(|(core_irq_src & wake_mask)))[*3];
    endsequence
    sequence s_deep_resume;
        deep ##1 core_clk_en;
    endsequence
    property p_wfi_gate; s_wfi_idle |=> !core_clk_en; endproperty
    a_wfi_gate: assert property (p_wfi_gate) else $error("core clock not gated");
    property p_gate_exit;
        !core_clk_en && !deep && |(core_irq_src & wake_mask) |-> ##[1:4] core_clk_en;
    endproperty
    a_gate_exit: assert property (p_gate_exit) else $error("clock gate not left");
    property p_cg_resume;
        $rose(core_clk_en) && !$past(deep) |-> core_boot_mode == $past(core_boot_mode);
    endproperty
    a_cg_resume: assert property (p_cg_resume) else $error("boot after gate");
    property p_deep_boot; s_deep_resume |-> ##[0:1] core_boot_mode; endproperty
    a_deep_boot: assert property (p_deep_boot) else $error("no boot after wake");
    property p_deep_wake;
        deep && (io_wake || rtc_wake && power_en.low_current_regulator) |-> ##[1:4] core_clk_en;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("deep wake missed");
    property p_sleep_entry;
        reg_wr && reg_addr == PSWC_REG_CTRL && |reg_wdata[1:0] |-> ##2 !core_clk_en && deep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    property p_rails;
        power_en.bandgap == power_en.fast_rc_osc && deep == !power_en.fast_rc_osc;
    endproperty
    a_rails: assert property (p_rails) else $error("normal-only rails wrong");
    property p_off_rails;
        !power_en.low_current_regulator |-> !(power_en.slow_rc_osc || power_en.rtc || !deep);
    endproperty
    a_off_rails: assert property (p_off_rails) else $error("off rails wrong");
    property p_ramp_len; $fell(chip_reset) |-> rst_run == 5'h10; endproperty
    a_ramp_len: assert property (p_ramp_len) else $error("chip reset length");
    property p_clk_switch;
        main_clk_sel != $past(main_clk_sel) && main_clk_sel != PSWC_CLK_RC
            |-> $past(crystal_ready) && (!main_clk_sel[1] || $past(dll_lock));
    endproperty
    a_clk_switch: assert property (p_clk_switch) else $error("early clock switch");
endmodule // pswc_ctrl_chk

bind pswc_ctrl pswc_ctrl_chk #(.IRQ_SRC(IRQ_SRC)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .core_wfi(core_wfi),
    .core_irq_src(core_irq_src), .core_clk_en(core_clk_en), .core_boot_mode(core_boot_mode),
    .io_wake(io_wake), .rtc_wake(rtc_wake), .crystal_ready(crystal_ready), .dll_lock(dll_lock),
    .power_en(power_en), .main_clk_sel(main_clk_sel), .chip_reset(chip_reset));

//--- test/pswc_core_model.sv
// cpu core model: wait-for-interrupt requests and interrupt/event levels
module pswc_core_model
    import pswc_pkg::*;
#(
    parameter int IRQ_SRC = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // commands from the bench
    input wire logic sleep_req,
    input wire logic [IRQ_SRC-1:0] irq_req,
    // controller side
    input wire logic core_clk_en,
    output logic core_wfi,
    output logic [IRQ_SRC-1:0] core_irq_src
);
    logic gated;
    assign core_irq_src = irq_req;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_wfi <= 1'b0;
            gated <= 1'b0;
        end else begin
            gated <= !core_clk_en;
            if (sleep_req) begin
                core_wfi <= 1'b1;
            end else if (gated && core_clk_en) begin
                // wait retires only once the clock is back, as a real core would
                core_wfi <= 1'b0;
            end
        end
    end
endmodule // pswc_core_model

//--- test/pswc_ctrl_test.sv
// testbench: scenarios for the power state and wake controller
module pswc_ctrl_test
    import pswc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, reg_wr, reg_rd, irq, core_wfi, core_clk_en, core_boot_mode;
    logic io_wake, rtc_wake, crystal_ready, dll_lock, dll_en, chip_reset, sleep_req;
    logic [7:0] reg_addr, domain_en;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] core_irq_src, irq_req;
    logic [12:0] supply_mv;
    logic [1:0] main_clk_sel;
    logic probe_test_boot, probe_test_part, crystal_osc_en;
    pswc_power_t power_en;
    int mismatches, n_tests;
    pswc_ctrl #(.RAMP_WINDOW_CYC(50)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .core_wfi(core_wfi), .core_irq_src(core_irq_src),
        .core_clk_en(core_clk_en), .core_boot_mode(core_boot_mode), .io_wake(io_wake),
        .rtc_wake(rtc_wake), .ext_reset_n(1'b1), .uvlo_reset(1'b0), .supply_mv(supply_mv),
        .probe_test_part(probe_test_part), .crystal_ready(crystal_ready), .dll_lock(dll_lock),
        .cal_ref_tick(1'b0), .cal_osc_tick(1'b0), .power_en(power_en),
        .crystal_osc_en(crystal_osc_en),
        .dll_en(dll_en), .domain_en(domain_en), .main_clk_sel(main_clk_sel),
        .probe_test_boot(probe_test_boot), .chip_reset(chip_reset));
    pswc_core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .sleep_req(sleep_req),
        .irq_req(irq_req), .core_clk_en(core_clk_en), .core_wfi(core_wfi),
        .core_irq_src(core_irq_src));
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // bounded wait for the core clock to reach a level
    task automatic wait_en(input logic v);
        for (int i = 0; i < 40 && core_clk_en !== v; i++) cyc(1);
    endtask
    task automatic t_reset;
        cyc(5);
        chk(power_en, 6'h3f);
        chk(main_clk_sel, PSWC_CLK_RC);
        chk(probe_test_boot, 1'b0);
        rd(PSWC_REG_STATUS, 32'h0000_0004);
        rd(8'h40, 32'h0000_0000);
        wr(PSWC_REG_DOMAIN, 32'h0000_005a);
        cyc(1);
        chk(domain_en, 8'h5a);
        wr(PSWC_REG_DOMAIN, 32'h0000_0081);
        cyc(1);
        chk(domain_en, 8'h81);
    endtask
    task automatic t_gate;
        wr(PSWC_REG_STATUS, 32'h0000_0004);
        wr(PSWC_REG_WAKE_EN, 32'h0000_0008);
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        irq_req <= 16'h0020;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        wait_en(1'b0);
        chk(power_en, 6'h3f);
        cyc(10);
        chk(core_clk_en, 1'b0);
        @(posedge sys_clk);
        irq_req <= 16'h0028;
        wait_en(1'b1);
        chk(core_clk_en, 1'b1);
        chk(core_boot_mode, 1'b0);
        @(posedge sys_clk);
        irq_req <= 16'h0000;
    endtask
    task automatic t_sleep;
        wr(PSWC_REG_IRQ_MASK, 32'h0000_0001);
        wr(PSWC_REG_RETAIN, 32'h9abc_1234);
        wr(PSWC_REG_CTRL, 32'h0000_0005);
        cyc(1);
        chk(power_en, 6'h1a);
        chk(core_clk_en, 1'b0);
        @(posedge sys_clk);
        rtc_wake <= 1'b1;
        wait_en(1'b1);
        @(posedge sys_clk);
        rtc_wake <= 1'b0;
        chk(core_boot_mode, 1'b1);
        chk(irq, 1'b1);
        rd(PSWC_REG_RETAIN, 32'h9abc_1234);
        rd(PSWC_REG_CTRL, 32'h0000_0004);
        rd(PSWC_REG_IRQ_STAT, 32'h0000_0001);
        cyc(1);
        chk(irq, 1'b0);
    endtask
    task automatic t_off;
        wr(PSWC_REG_IRQ_MASK, 32'h0000_0000);
        wr(PSWC_REG_CTRL, 32'h0000_0003);
        cyc(1);
        chk(power_en, 6'h00);
        chk(crystal_osc_en, 1'b0);
        @(posedge sys_clk);
        rtc_wake <= 1'b1;
        cyc(10);
        chk(core_clk_en, 1'b0);
        @(posedge sys_clk);
        rtc_wake <= 1'b0;
        io_wake <= 1'b1;
        wait_en(1'b1);
        @(posedge sys_clk);
        io_wake <= 1'b0;
        chk(core_clk_en, 1'b1);
        chk(irq, 1'b0);
        rd(PSWC_REG_IRQ_STAT, 32'h0000_0001);
    endtask
    task automatic t_clock;
        wr(PSWC_REG_CTRL, 32'h0000_0010);
        cyc(8);
        chk(main_clk_sel, PSWC_CLK_RC);
        @(posedge sys_clk);
        crystal_ready <= 1'b1;
        cyc(6);
        chk(main_clk_sel, PSWC_CLK_XTAL);
        wr(PSWC_REG_CTRL, 32'h0000_0060);
        cyc(8);
        chk(main_clk_sel == PSWC_CLK_DLL32, 1'b0);
        chk(dll_en, 1'b1);
        chk(crystal_osc_en, 1'b1);
        @(posedge sys_clk);
        dll_lock <= 1'b1;
        cyc(6);
        chk(main_clk_sel, PSWC_CLK_DLL32);
        wr(PSWC_REG_CTRL, 32'h0000_0070);
        cyc(6);
        chk(main_clk_sel, PSWC_CLK_DLL48);
    endtask
    task automatic t_ramp;
        int n;
        @(posedge sys_clk);
        supply_mv <= 13'h0dac;
        cyc(60);
        chk(chip_reset, 1'b0);
        @(posedge sys_clk);
        supply_mv <= 13'h1068;
        probe_test_part <= 1'b1;
        for (int i = 0; i < 60 && chip_reset !== 1'b1; i++) cyc(1);
        n = 0;
        while (chip_reset === 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(n, 32'h0000_0010);
        // the chip reset re-reads the strap once the settle count has reached SETTLE_STRAP again
        cyc(3);
        chk(probe_test_boot, 1'b1);
        chk(main_clk_sel, PSWC_CLK_RC);
        rd(PSWC_REG_STATUS, 32'h0000_004c);
        rd(PSWC_REG_IRQ_STAT, 32'h0000_0002);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, io_wake, rtc_wake, crystal_ready, dll_lock, sleep_req} = 7'h00;
        probe_test_part = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        irq_req = 16'h0000;
        supply_mv = 13'h0bb8;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_gate();
        t_sleep();
        t_off();
        t_clock();
        t_ramp();
        end_sim();
    end
    // the scenarios need well under a thousand cycles
    initial begin
        #(20 * 20_000);
        mismatches++;
        end_sim();
    end
endmodule // pswc_ctrl_test
